// file: pkg/uvm_regs_pkg.sv
package uvmr_pkg;

  // ----------------------------------------------------------------
  // Register addresses (6-bit ULPI immediate space)
  // ----------------------------------------------------------------
  localparam logic [5:0] UVMR_VEND_LO     = 6'h30;
  localparam logic [5:0] UVMR_VEND_HI     = 6'h3F;
  localparam logic [5:0] UVMR_AUDIO_ADDR  = 6'h33;
  localparam logic [5:0] UVMR_IDC_WR      = 6'h36;
  localparam logic [5:0] UVMR_IDC_SET     = 6'h37;
  localparam logic [5:0] UVMR_IDC_CLR     = 6'h38;
  localparam logic [5:0] UVMR_IOP_WR      = 6'h39;
  localparam logic [5:0] UVMR_IOP_SET     = 6'h3A;
  localparam logic [5:0] UVMR_IOP_CLR     = 6'h3B;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] UVMR_AUDIO_KEY   = 4'hA;
  localparam logic [7:0] UVMR_IDC_WMASK   = 8'h70;
  localparam logic [7:0] UVMR_IOP_WMASK   = 8'hFE;
  localparam logic [7:0] UVMR_IOP_RESET   = 8'h04;
  localparam int         UVMR_IDC_DONE    = 3;
  localparam int         UVMR_IDC_TRIG    = 4;
  localparam int         UVMR_IDC_IRQEN   = 6;
  localparam int         UVMR_IOP_SWAP    = 1;
  localparam int         UVMR_IOP_PU_P    = 4;
  localparam int         UVMR_IOP_PU_M    = 5;
  localparam int         UVMR_IOP_SER_LSB = 2;
  localparam int         UVMR_IOP_BUS_LSB = 6;
  localparam logic [1:0] UVMR_SUPPLY_3V3  = 2'h0;
  localparam logic [2:0] UVMR_CODE_ZERO   = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int UVMR_CLK_MHZ        = 20;
  localparam int UVMR_CONV_TIME_US   = 282;
  localparam int UVMR_CONV_CYCLES    = UVMR_CONV_TIME_US * UVMR_CLK_MHZ;
  localparam int UVMR_CNT_W          = 13;

  typedef enum logic [1:0] {
    UVMR_MODE_SYNC,
    UVMR_MODE_SERIAL,
    UVMR_MODE_LOWPOWER,
    UVMR_MODE_UART
  } uvmr_mode_t;

  typedef struct packed {
    logic       req;
    logic       write;
    logic [5:0] addr;
    logic [7:0] wdata;
  } uvmr_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } uvmr_rsp_t;

  typedef struct packed {
    logic       audio_mode;
    logic       line_pair_swap;
    logic       plus_line_detect_pullup;
    logic       minus_line_detect_pullup;
    logic [1:0] supply_sel;
  } uvmr_analog_t;

endpackage

// file: rtl/uvmr_conv_timer.sv
`timescale 1ns/1ps
module uvmr_conv_timer
  import uvmr_pkg::*;
#(
  parameter int CONV_CYCLES = UVMR_CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // Control
  input  wire logic start,
  output logic      busy,
  output logic      finish
);
  logic [UVMR_CNT_W-1:0] count;
  logic [UVMR_CNT_W-1:0] next_count;
  logic                  next_busy;
  logic                  next_finish;

  localparam logic [UVMR_CNT_W-1:0] LAST = UVMR_CNT_W'(CONV_CYCLES - 1);

  always_comb
  begin
    next_count  = count;
    next_busy   = busy;
    next_finish = 1'b0;
    if (busy)
    begin
      if (count == LAST)
      begin
        next_busy   = 1'b0;
        next_finish = 1'b1;
        next_count  = '0;
      end
      else
      begin
        next_count = count + 1'b1;
      end
    end
    else if (start)
    begin
      next_busy  = 1'b1;
      next_count = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      count  <= '0;
      busy   <= 1'b0;
      finish <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      busy   <= next_busy;
      finish <= next_finish;
    end
  end
endmodule

// file: rtl/uvmr_regs.sv
`timescale 1ns/1ps
// How it works
// - Vendor space 30h-3Fh, immediate register access
// - Audio mode only when key equals 1010
// - ID register: 36h write, 37h set, 38h clear
// - Three-bit resistance code in bits 2:0
// - Done flag after 282 us measurement
// - Reading code here clears done; carkit read not
// - Trigger bit starts measurement, self-clears when done
// - Either enable raises alt_int on done
// - IO register: 39h write, 3Ah set, 3Bh clear
// - Bit 1 swaps DP and DM, not speaker
// - UART supply from bits 3:2 after transmit enable
// - Audio mode forces 3.3V supply
// - Detect pull-ups bits 4/5, forced in UART
// - Sync/serial/low-power supply from bits 7:6
module uvmr_regs
  import uvmr_pkg::*;
#(
  parameter int CONV_CYCLES = UVMR_CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         srst,
  // Register access from the ULPI command decoder
  input  uvmr_pkg::uvmr_req_t reg_req,
  output uvmr_pkg::uvmr_rsp_t reg_rsp,
  // Carkit-side view of the conversion
  input  wire logic         carkit_irq_enable,
  input  wire logic         carkit_code_read,
  output logic              alt_int,
  // PHY mode and measurement result
  input  uvmr_pkg::uvmr_mode_t phy_mode,
  input  wire logic         serial_tx_drive_enable,
  input  wire logic [2:0]   id_meas_code,
  // Analog controls and the carkit view of code, done and busy
  output uvmr_pkg::uvmr_analog_t analog_ctl,
  output logic [2:0]        id_resistor_code_out,
  output logic              id_conv_complete_out,
  output logic              id_conv_busy
);
  import uvmr_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0] audio_mode_key;
  logic [2:0] id_resistor_code;
  logic       id_conv_complete;
  logic       id_conv_trigger;
  logic       id_conv_irq_enable;
  logic       line_pair_swap;
  logic [1:0] serial_mode_supply_sel;
  logic       plus_line_detect_pullup;
  logic       minus_line_detect_pullup;
  logic [1:0] bus_mode_supply_sel;

  logic [3:0] next_audio_mode_key;
  logic [2:0] next_id_resistor_code;
  logic       next_id_conv_complete;
  logic       next_id_conv_trigger;
  logic       next_id_conv_irq_enable;
  logic       next_line_pair_swap;
  logic [1:0] next_serial_mode_supply_sel;
  logic       next_plus_line_detect_pullup;
  logic       next_minus_line_detect_pullup;
  logic [1:0] next_bus_mode_supply_sel;

  // Output registers and the UART supply arming flag
  uvmr_rsp_t    next_reg_rsp;
  uvmr_analog_t next_analog_ctl;
  logic         next_alt_int;
  logic         uart_supply_armed;
  logic         next_uart_supply_armed;

  logic       timer_start;
  logic       timer_busy;
  logic       timer_finish;
  logic [7:0] idc_image;
  logic [7:0] iop_image;
  logic [7:0] idc_new;
  logic [7:0] iop_new;
  logic       rd_idc;
  logic       audio_on;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Set and clear aliases share one merge path with the plain write
  function automatic logic [7:0] apply_access(input logic [7:0] cur,
                                              input logic [7:0] wd,
                                              input logic [1:0] kind,
                                              input logic [7:0] mask);
    logic [7:0] res;
    res = cur;
    if (kind == 2'h0)
      res = wd;
    else if (kind == 2'h1)
      res = cur | wd;
    else
      res = cur & ~wd;
    return (res & mask) | (cur & ~mask);
  endfunction

  // Offset from the base address selects write, set or clear
  function automatic logic [1:0] alias_kind(input logic [5:0] a, input logic [5:0] base);
    return 2'(a - base);
  endfunction

  // The ID and IO registers each answer on three consecutive addresses
  function automatic logic in_range(input logic [5:0] a, input logic [5:0] base);
    return (a >= base) && (a <= base + 6'h2);
  endfunction

  assign idc_image = {1'b0, id_conv_irq_enable, 1'b0, id_conv_trigger,
                      id_conv_complete, id_resistor_code};
  assign iop_image = {bus_mode_supply_sel, minus_line_detect_pullup,
                      plus_line_detect_pullup, serial_mode_supply_sel,
                      line_pair_swap, 1'b0};
  // Exact key compare: a stray write cannot half-enable the audio switch
  assign audio_on  = (audio_mode_key == UVMR_AUDIO_KEY);
  assign rd_idc    = reg_req.req && !reg_req.write
                     && in_range(reg_req.addr, UVMR_IDC_WR);

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_comb
  begin
    next_audio_mode_key           = audio_mode_key;
    next_id_resistor_code         = id_resistor_code;
    next_id_conv_complete         = id_conv_complete;
    next_id_conv_trigger          = id_conv_trigger;
    next_id_conv_irq_enable       = id_conv_irq_enable;
    next_line_pair_swap           = line_pair_swap;
    next_serial_mode_supply_sel   = serial_mode_supply_sel;
    next_plus_line_detect_pullup  = plus_line_detect_pullup;
    next_minus_line_detect_pullup = minus_line_detect_pullup;
    next_bus_mode_supply_sel      = bus_mode_supply_sel;
    idc_new     = idc_image;
    iop_new     = iop_image;
    timer_start = 1'b0;

    // Only the vendor window is decoded; other addresses are ignored
    if (reg_req.req && reg_req.write && reg_req.addr >= UVMR_VEND_LO
        && reg_req.addr <= UVMR_VEND_HI)
    begin
      if (reg_req.addr == UVMR_AUDIO_ADDR)
      begin
        next_audio_mode_key = reg_req.wdata[3:0];
      end
      else if (in_range(reg_req.addr, UVMR_IDC_WR))
      begin
        idc_new = apply_access(idc_image, reg_req.wdata,
                               alias_kind(reg_req.addr, UVMR_IDC_WR), UVMR_IDC_WMASK);
        next_id_conv_irq_enable = idc_new[UVMR_IDC_IRQEN];
        // Bit 5 is not stored: the link keeps it zero anyway
        if (idc_new[UVMR_IDC_TRIG] && !id_conv_trigger)
        begin
          next_id_conv_trigger = 1'b1;
          timer_start          = 1'b1;
        end
        else if (!idc_new[UVMR_IDC_TRIG])
        begin
          // Clearing the trigger does not abort a running measurement
          next_id_conv_trigger = timer_busy;
        end
      end
      else if (in_range(reg_req.addr, UVMR_IOP_WR))
      begin
        iop_new = apply_access(iop_image, reg_req.wdata,
                               alias_kind(reg_req.addr, UVMR_IOP_WR), UVMR_IOP_WMASK);
        // Bit 0 is reserved and never stored
        next_line_pair_swap           = iop_new[UVMR_IOP_SWAP];
        next_serial_mode_supply_sel   = iop_new[UVMR_IOP_SER_LSB +: 2];
        next_plus_line_detect_pullup  = iop_new[UVMR_IOP_PU_P];
        next_minus_line_detect_pullup = iop_new[UVMR_IOP_PU_M];
        next_bus_mode_supply_sel      = iop_new[UVMR_IOP_BUS_LSB +: 2];
      end
    end

    // Read of the code clears done; a finishing measurement wins
    if (rd_idc || carkit_code_read && 1'b0)
      next_id_conv_complete = 1'b0;
    // A trigger write landing in the finishing cycle is absorbed; the link
    // should wait for done before asking for the next measurement
    if (timer_finish)
    begin
      next_id_conv_complete = 1'b1;
      next_id_resistor_code = id_meas_code;
      next_id_conv_trigger  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data, interrupt and analog controls
  // ----------------------------------------------------------------
  always_comb
  begin
    next_reg_rsp           = '0;
    next_uart_supply_armed = uart_supply_armed;
    next_analog_ctl        = '0;
    next_reg_rsp.valid     = reg_req.req && !reg_req.write;
    // Data shows only with a read answer, so idle cycles read as zero
    if (!next_reg_rsp.valid)
      next_reg_rsp.rdata = 8'h00;
    else if (reg_req.addr == UVMR_AUDIO_ADDR)
      next_reg_rsp.rdata = {4'h0, audio_mode_key};
    else if (in_range(reg_req.addr, UVMR_IDC_WR))
      next_reg_rsp.rdata = idc_image;
    else if (in_range(reg_req.addr, UVMR_IOP_WR))
      next_reg_rsp.rdata = iop_image;
    else
      next_reg_rsp.rdata = 8'h00;

    // alt_int is the level of done gated by either enable
    next_alt_int = next_id_conv_complete
                   && (next_id_conv_irq_enable || carkit_irq_enable);

    // Arming needs transmit enable inside UART mode; leaving UART disarms
    if (phy_mode != UVMR_MODE_UART)
      next_uart_supply_armed = 1'b0;
    else if (serial_tx_drive_enable)
      next_uart_supply_armed = 1'b1;

    next_analog_ctl.audio_mode     = audio_on;
    next_analog_ctl.line_pair_swap = line_pair_swap;
    // Pull-ups follow the live mode, so UART forcing needs no stored copy
    next_analog_ctl.plus_line_detect_pullup =
      plus_line_detect_pullup || phy_mode == UVMR_MODE_UART;
    next_analog_ctl.minus_line_detect_pullup =
      minus_line_detect_pullup || phy_mode == UVMR_MODE_UART;
    if (audio_on)
      next_analog_ctl.supply_sel = UVMR_SUPPLY_3V3;
    else if (phy_mode == UVMR_MODE_UART && next_uart_supply_armed)
      next_analog_ctl.supply_sel = serial_mode_supply_sel;
    else
      next_analog_ctl.supply_sel = bus_mode_supply_sel;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      audio_mode_key           <= 4'h0;
      id_resistor_code         <= UVMR_CODE_ZERO;
      id_conv_complete         <= 1'b0;
      id_conv_trigger          <= 1'b0;
      id_conv_irq_enable       <= 1'b0;
      line_pair_swap           <= 1'b0;
      // Supply fields start from the IO register's reset image
      serial_mode_supply_sel   <= UVMR_IOP_RESET[UVMR_IOP_SER_LSB +: 2];
      plus_line_detect_pullup  <= 1'b0;
      minus_line_detect_pullup <= 1'b0;
      bus_mode_supply_sel      <= UVMR_IOP_RESET[UVMR_IOP_BUS_LSB +: 2];
      reg_rsp                  <= '0;
      analog_ctl               <= '0;
      alt_int                  <= 1'b0;
      uart_supply_armed        <= 1'b0;
      id_resistor_code_out     <= UVMR_CODE_ZERO;
      id_conv_complete_out     <= 1'b0;
      id_conv_busy             <= 1'b0;
    end
    else
    begin
      audio_mode_key           <= next_audio_mode_key;
      id_resistor_code         <= next_id_resistor_code;
      id_conv_complete         <= next_id_conv_complete;
      id_conv_trigger          <= next_id_conv_trigger;
      id_conv_irq_enable       <= next_id_conv_irq_enable;
      line_pair_swap           <= next_line_pair_swap;
      serial_mode_supply_sel   <= next_serial_mode_supply_sel;
      plus_line_detect_pullup  <= next_plus_line_detect_pullup;
      minus_line_detect_pullup <= next_minus_line_detect_pullup;
      bus_mode_supply_sel      <= next_bus_mode_supply_sel;
      reg_rsp                  <= next_reg_rsp;
      analog_ctl               <= next_analog_ctl;
      alt_int                  <= next_alt_int;
      uart_supply_armed        <= next_uart_supply_armed;
      // Carkit view: code and done read here without side effects
      id_resistor_code_out     <= next_id_resistor_code;
      id_conv_complete_out     <= next_id_conv_complete;
      id_conv_busy             <= timer_start || timer_busy;
    end
  end

  // ----------------------------------------------------------------
  // Measurement timer
  // ----------------------------------------------------------------
  // Same clock as the registers, so start and finish need no handshake
  uvmr_conv_timer #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_timer (
    .clock  (clock),
    .srst   (srst),
    .start  (timer_start),
    .busy   (timer_busy),
    .finish (timer_finish)
  );

endmodule

// file: verif/uvmr_regs_asserts.sv
`timescale 1ns/1ps
module uvmr_regs_asserts
  import uvmr_pkg::*;
#(
  parameter int CONV_CYCLES = UVMR_CONV_CYCLES
)
(
  // Clock and reset
  input wire logic             clock,
  input wire logic             srst,
  // Register access
  input uvmr_pkg::uvmr_req_t   reg_req,
  input uvmr_pkg::uvmr_rsp_t   reg_rsp,
  // Conversion and mode
  input wire logic             carkit_irq_enable,
  input wire logic             carkit_code_read,
  input wire logic             alt_int,
  input uvmr_pkg::uvmr_mode_t  phy_mode,
  input wire logic             serial_tx_drive_enable,
  input wire logic [2:0]       id_meas_code,
  input uvmr_pkg::uvmr_analog_t analog_ctl,
  input wire logic [2:0]       id_resistor_code_out,
  input wire logic             id_conv_complete_out,
  input wire logic             id_conv_busy
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  wire logic rd = reg_req.req && !reg_req.write;
  wire logic wr = reg_req.req && reg_req.write;
  logic      swap_exp;
  // Swap lands two cycles after the write, so compare three cycles later
  always_ff @(posedge clock)
    if (wr && reg_req.addr == UVMR_IOP_WR)
      swap_exp <= reg_req.wdata[1];
  int unsigned busy_len;
  // Long measurement is counted here rather than unrolled in a property
  always_ff @(posedge clock)
    if (srst || !id_conv_busy)
      busy_len <= 0;
    else
      busy_len <= busy_len + 1;
  AST_CONV_TIME: assert property ($fell(id_conv_busy) |-> busy_len == CONV_CYCLES + 1)
    else $error("measurement length");
  AST_RD_ANSWER: assert property (rd |=> reg_rsp.valid)
    else $error("read not answered");
  AST_NO_STRAY: assert property (!rd |=> !reg_rsp.valid)
    else $error("stray read answer");
  AST_KEY: assert property (wr && reg_req.addr == UVMR_AUDIO_ADDR |=> ##1
    analog_ctl.audio_mode == $past(reg_req.wdata[3:0] == UVMR_AUDIO_KEY, 2))
    else $error("audio key decode");
  AST_AUDIO_SUPPLY: assert property (analog_ctl.audio_mode |->
    analog_ctl.supply_sel == UVMR_SUPPLY_3V3) else $error("audio supply");
  AST_IRQ_SRC: assert property (alt_int |-> id_conv_complete_out)
    else $error("alt_int without done");
  AST_IRQ_CARKIT: assert property ($rose(id_conv_complete_out) &&
    $past(carkit_irq_enable) |-> alt_int) else $error("carkit enable ignored");
  AST_DONE_SRC: assert property ($rose(id_conv_complete_out) |->
    $past(id_conv_busy)) else $error("done without measurement");
  AST_CODE: assert property ($rose(id_conv_complete_out) |->
    id_resistor_code_out == $past(id_meas_code)) else $error("code not loaded");
  AST_SWAP: assert property ($past(wr && reg_req.addr == UVMR_IOP_WR, 3) |->
    analog_ctl.line_pair_swap == swap_exp) else $error("swap not applied");
  AST_PULLUP: assert property ($past(phy_mode) == UVMR_MODE_UART && !$past(srst) |->
    analog_ctl.plus_line_detect_pullup && analog_ctl.minus_line_detect_pullup)
    else $error("pull-ups not forced");
  cover property ($rose(id_conv_complete_out));
  cover property ($rose(alt_int));
  cover property ($rose(analog_ctl.audio_mode));
endmodule
bind uvmr_regs uvmr_regs_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.*);

// file: verif/uvmr_link_model.sv
`timescale 1ns/1ps
module uvmr_link_model
  import uvmr_pkg::*;
(
  // Clock
  input wire logic            clock,
  // Register access
  output uvmr_pkg::uvmr_req_t reg_req,
  input  uvmr_pkg::uvmr_rsp_t reg_rsp,
  // Converter side
  input  wire logic           id_conv_busy,
  output logic [2:0]          id_meas_code
);
  logic [2:0] code_sel;
  initial
  begin
    reg_req = '0;
    id_meas_code = 3'h0;
    code_sel = 3'h5;
  end
  // Result holds only while measuring; idle lines wander on purpose
  always @(negedge clock)
    id_meas_code <= id_conv_busy ? code_sel : ~id_meas_code;
  // Immediate register access, one byte per request
  task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
    @(negedge clock);
    reg_req <= '{1'b1, w, a, (a == UVMR_IDC_WR || a == UVMR_IDC_SET) ? d & 8'hDF : d};
    // The answer stands one cycle only, so take it at the first falling edge
    @(negedge clock);
    q = reg_rsp.rdata;
    v = reg_rsp.valid;
    reg_req <= '0;
  endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import uvmr_pkg::*;
  localparam int CONV = 8;
  logic clock, srst, carkit_irq_enable, carkit_code_read, serial_tx_drive_enable;
  logic alt_int, id_conv_complete_out, id_conv_busy;
  logic [2:0] id_meas_code, id_resistor_code_out;
  uvmr_req_t reg_req;
  uvmr_rsp_t reg_rsp;
  uvmr_mode_t phy_mode;
  uvmr_analog_t analog_ctl;
  int n_checks = 0;
  int n_mismatch = 0;
  int n;
  uvmr_link_model lm (.clock(clock), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .id_conv_busy(id_conv_busy), .id_meas_code(id_meas_code));
  uvmr_regs #(.CONV_CYCLES(CONV)) dut (.clock(clock), .srst(srst), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .carkit_irq_enable(carkit_irq_enable),
    .carkit_code_read(carkit_code_read), .alt_int(alt_int), .phy_mode(phy_mode),
    .serial_tx_drive_enable(serial_tx_drive_enable), .id_meas_code(id_meas_code),
    .analog_ctl(analog_ctl), .id_resistor_code_out(id_resistor_code_out),
    .id_conv_complete_out(id_conv_complete_out), .id_conv_busy(id_conv_busy));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    lm.access(1'b1, a, d, q, v);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       v;
    lm.access(1'b0, a, 8'h00, q, v);
    chk({7'h0, v}, 8'h01);
    chk(q, exp);
  endtask
  // Mode change settles over two edges before the supply is judged
  task automatic supply(input uvmr_mode_t m, input logic [1:0] exp);
    phy_mode = m;
    repeat (2) @(negedge clock);
    chk({6'h0, analog_ctl.supply_sel}, {6'h0, exp});
  endtask
  task automatic wait_done(output int k);
    k = 0;
    while (id_conv_complete_out !== 1'b1 && k < 100)
    begin
      @(negedge clock);
      k++;
    end
    if (k >= 100)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  initial
  begin
    srst = 1'b1;
    carkit_irq_enable = 1'b0;
    carkit_code_read = 1'b0;
    serial_tx_drive_enable = 1'b0;
    phy_mode = UVMR_MODE_SYNC;
    repeat (12) @(negedge clock);
    srst = 1'b0;
    rd(6'h33, 8'h00);
    rd(6'h36, 8'h00);
    rd(6'h39, 8'h04);
    rd(6'h30, 8'h00);
    rd(6'h3F, 8'h00);
    wr(6'h33, 8'hFA);
    rd(6'h33, 8'h0A);
    chk({7'h0, analog_ctl.audio_mode}, 8'h01);
    phy_mode = UVMR_MODE_UART;
    serial_tx_drive_enable = 1'b1;
    supply(UVMR_MODE_UART, 2'h0);
    wr(6'h33, 8'h0B);
    supply(UVMR_MODE_UART, 2'h1);
    chk({6'h0, analog_ctl.plus_line_detect_pullup, analog_ctl.minus_line_detect_pullup},
        8'h03);
    // Leave the serial mode through reset, as the link should
    srst = 1'b1;
    phy_mode = UVMR_MODE_SYNC;
    serial_tx_drive_enable = 1'b0;
    @(negedge clock);
    srst = 1'b0;
    rd(6'h33, 8'h00);
    wr(6'h39, 8'hFF);
    rd(6'h39, 8'hFE);
    chk({7'h0, analog_ctl.line_pair_swap}, 8'h01);
    wr(6'h3B, 8'h0C);
    rd(6'h3A, 8'hF2);
    wr(6'h3A, 8'h01);
    rd(6'h3B, 8'hF2);
    for (int i = 0; i < 3; i++)
      supply(uvmr_mode_t'(i), 2'h3);
    wr(6'h39, 8'h58);
    for (int i = 0; i < 3; i++)
      supply(uvmr_mode_t'(i), 2'h1);
    chk({6'h0, analog_ctl.plus_line_detect_pullup, analog_ctl.minus_line_detect_pullup},
        8'h02);
    chk({7'h0, analog_ctl.line_pair_swap}, 8'h00);
    supply(UVMR_MODE_UART, 2'h1);
    serial_tx_drive_enable = 1'b1;
    supply(UVMR_MODE_UART, 2'h2);
    chk({6'h0, analog_ctl.plus_line_detect_pullup, analog_ctl.minus_line_detect_pullup},
        8'h03);
    srst = 1'b1;
    phy_mode = UVMR_MODE_SYNC;
    serial_tx_drive_enable = 1'b0;
    @(negedge clock);
    srst = 1'b0;
    rd(6'h39, 8'h04);
    wr(6'h37, 8'h70);
    wait_done(n);
    chk(8'(n), 8'(CONV + 1));
    chk({5'h0, id_resistor_code_out}, 8'h05);
    chk({7'h0, alt_int}, 8'h01);
    carkit_code_read = 1'b1;
    @(negedge clock);
    carkit_code_read = 1'b0;
    rd(6'h37, 8'h4D);
    rd(6'h38, 8'h45);
    chk({7'h0, alt_int}, 8'h00);
    wr(6'h38, 8'h40);
    carkit_irq_enable = 1'b1;
    lm.code_sel = 3'h7;
    wr(6'h36, 8'h10);
    rd(6'h36, 8'h15);
    chk({7'h0, id_conv_busy}, 8'h01);
    wait_done(n);
    chk({7'h0, alt_int}, 8'h01);
    rd(6'h36, 8'h0F);
    carkit_irq_enable = 1'b0;
    wrap_up();
  end
endmodule
